/* src/debug_pin_driver.sv */
`default_nettype none

module debug_pin_driver import radio_debug_pkg::*; (
    input  wire logic                   clk,           // System clock.
    input  wire logic                   sys_rst,       // Synchronous reset, active high.
    input  wire debug_cfg_s             cfg,           // Selector and polarity for this pin.
    input  wire logic [NUM_SIGNALS-1:0] radio_signals, // Internal radio signals to pick from.
    output logic                        pin            // Registered debug pin level.
);

    logic next_pin;

    // ==========================================================================
    // Signal selection and polarity
    // ==========================================================================
    // Picks one internal signal and flips it when active low is chosen.
    always_comb begin
        next_pin = radio_signals[cfg.select] ^ cfg.invert; // see RQ1
    end

    // Registers the pin so that it never glitches on a selector change.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin <= 1'b0;
        end else begin
            pin <= next_pin;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_invert_active_low: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
        (cfg.invert && radio_signals[cfg.select]) |=> !pin)
        else $error("Inverted pin did not go low for an active signal.");

    a_plain_active_high: assert property (@(posedge clk) disable iff (sys_rst) // see RQ1
        (!cfg.invert && radio_signals[cfg.select]) |=> pin)
        else $error("Non-inverted pin did not go high for an active signal.");

endmodule

`default_nettype wire

/* src/preamble_quality_counter.sv */
`default_nettype none

module preamble_quality_counter import radio_debug_pkg::*; (
    input  wire logic             clk,        // System clock.
    input  wire logic             sys_rst,    // Synchronous reset, active high.
    input  wire logic             restart,    // Clears the count at a new reception.
    input  wire logic             bit_valid,  // One-cycle strobe with a received bit.
    input  wire logic             bit_in,     // Received bit value.
    input  wire logic [PQT_W-1:0] threshold,  // Quality threshold field.
    output logic                  quality_ok  // Sync detection is allowed.
);

    logic [PQ_COUNT_W-1:0] count;
    logic [PQ_COUNT_W-1:0] next_count;
    logic                  prev_bit;
    logic                  next_prev_bit;
    logic                  have_prev;
    logic                  next_have_prev;

    // ==========================================================================
    // Counter update
    // ==========================================================================
    // Transitions count up by one, repeated bits take eight off, both saturate.
    always_comb begin
        next_count     = count;
        next_prev_bit  = prev_bit;
        next_have_prev = have_prev;
        if (restart) begin
            next_count     = PQ_ZERO;
            next_have_prev = 1'b0;
        end else if (bit_valid) begin
            next_prev_bit  = bit_in;
            next_have_prev = 1'b1;
            if (have_prev && (bit_in == prev_bit)) begin
                next_count = (count < PQ_DEC) ? PQ_ZERO : count - PQ_DEC; // see RQ10
            end else if (have_prev && (count != PQ_MAX)) begin
                next_count = count + PQ_INC; // see RQ10
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count     <= PQ_ZERO;
            prev_bit  <= 1'b0;
            have_prev <= 1'b0;
        end else begin
            count     <= next_count;
            prev_bit  <= next_prev_bit;
            have_prev <= next_have_prev;
        end
    end

    // A zero threshold always accepts; otherwise the count must reach four times it.
    assign quality_ok = (threshold == '0) || (count >= {threshold, PQ_SCALE_PAD}); // see RQ10

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_repeat_drops_eight: assert property (@(posedge clk) disable iff (sys_rst) // see RQ10
        (!restart && bit_valid && have_prev && bit_in == prev_bit && count >= PQ_DEC)
        |=> count == $past(count) - PQ_DEC)
        else $error("Repeated bit did not reduce the quality count by eight.");

    a_zero_threshold_open: assert property (@(posedge clk) disable iff (sys_rst) // see RQ10
        (threshold == '0) |-> quality_ok)
        else $error("Zero threshold did not accept the sync word.");

endmodule

`default_nettype wire

/* src/radio_debug_out_sync_regs.sv */
// The implementer's own choice: the plain strobed port.
`default_nettype none

// Overview of operation
// RQ1: Bit 6 of each debug register inverts its pin: 0 active high, 1 active low.
// RQ2: Bits 5:0 of the first debug register select pin two's signal; reset zero.
// RQ3: Bits 5:0 of the second debug register select pin one's signal; reset zero.
// RQ4: Bits 5:0 of the third debug register select pin zero's signal; reset zero.
// RQ5: Bit 7 of the second debug register picks minimum or maximum pin drive; reset zero.
// RQ6: Sync word bits 15:8 live in the high byte register, reset 0xD3, read/write.
// RQ7: Sync word bits 7:0 live in the low byte register, reset 0x91, read/write.
// RQ8: The measured receiver frequency offset is readable as a status register.
// RQ9: Software should use deep sleep when idle; the sleep timer works in the lighter one.
// RQ10: Sync detection waits until preamble quality reaches four times the threshold; zero accepts.
// RQ11: Unused bit 7 of the first and third debug registers reads zero, ignores writes.
module radio_debug_out_sync_regs import radio_debug_pkg::*; (
    input  wire logic                   clk,                  // System clock, 100 MHz.
    input  wire logic                   sys_rst,              // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0]      reg_addr,             // Register address.
    input  wire logic [DATA_W-1:0]      reg_wdata,            // Register write data.
    input  wire logic                   reg_write,            // Write strobe, one cycle.
    input  wire logic                   reg_read,             // Read strobe, one cycle.
    output logic      [DATA_W-1:0]      reg_rdata,            // Read data, cycle after the strobe.
    input  wire logic [NUM_SIGNALS-1:0] radio_signals,        // Internal radio debug signals.
    input  wire logic [DATA_W-1:0]      freq_offset_estimate, // Measured frequency offset.
    input  wire logic                   rx_restart,           // Start of a new reception.
    input  wire logic                   rx_bit_valid,         // Strobe with a received bit.
    input  wire logic                   rx_bit,               // Received bit value.
    output logic                        debug_pin_two,        // Debug output pin two.
    output logic                        debug_pin_one,        // Debug output pin one.
    output logic                        debug_pin_zero,       // Debug output pin zero.
    output logic                        pin_drive_strength,   // 1 selects maximum pin drive.
    output logic                        preamble_ok,          // Preamble quality reached.
    output logic                        sync_detected         // One-cycle pulse on sync match.
);

    // ==========================================================================
    // State
    // ==========================================================================
    debug_cfg_s              dbg_cfg [DEBUG_PINS];
    debug_cfg_s              next_dbg_cfg [DEBUG_PINS];
    logic                    next_pin_drive_strength;
    logic [DATA_W-1:0]       sync_high;
    logic [DATA_W-1:0]       next_sync_high;
    logic [DATA_W-1:0]       sync_low;
    logic [DATA_W-1:0]       next_sync_low;
    logic [PQT_W-1:0]        preamble_quality_threshold;
    logic [PQT_W-1:0]        next_preamble_quality_threshold;
    logic [DATA_W-1:0]       next_reg_rdata;
    logic [SYNC_W-1:0]       rx_history;
    logic [SYNC_W-1:0]       next_rx_history;
    logic                    next_sync_detected;
    logic [DEBUG_PINS-1:0]   pin_level;

    // Packs one debug configuration into its register byte.
    function automatic logic [DATA_W-1:0] cfg_byte(input debug_cfg_s c, input logic top);
        cfg_byte = {top, c.invert, c.select};
    endfunction

    // Unpacks selector and polarity from a written byte; bit 7 is not kept.
    function automatic debug_cfg_s byte_cfg(input logic [DATA_W-1:0] b);
        byte_cfg = '{invert: b[INV_BIT], select: b[SEL_MSB:0]};
    endfunction

    // ==========================================================================
    // Register writes
    // ==========================================================================
    // Decodes a write strobe and updates the addressed register.
    always_comb begin
        next_dbg_cfg                    = dbg_cfg;
        next_pin_drive_strength         = pin_drive_strength;
        next_sync_high                  = sync_high;
        next_sync_low                   = sync_low;
        next_preamble_quality_threshold = preamble_quality_threshold;
        if (reg_write) begin
            if (reg_addr == ADDR_SYNC_HIGH) begin
                next_sync_high = reg_wdata; // see RQ6
            end else if (reg_addr == ADDR_SYNC_LOW) begin
                next_sync_low = reg_wdata; // see RQ7
            end else if (reg_addr == ADDR_PKT_CTRL) begin
                next_preamble_quality_threshold = reg_wdata[PQT_MSB:PQT_LSB]; // see RQ10
            end else if (reg_addr == ADDR_DEBUG_TWO) begin
                next_dbg_cfg[2] = byte_cfg(reg_wdata); // see RQ2, see RQ11
            end else if (reg_addr == ADDR_DEBUG_ONE) begin
                next_dbg_cfg[1]         = byte_cfg(reg_wdata); // see RQ3
                next_pin_drive_strength = reg_wdata[DRIVE_BIT]; // see RQ5
            end else if (reg_addr == ADDR_DEBUG_ZERO) begin
                next_dbg_cfg[0] = byte_cfg(reg_wdata); // see RQ4, see RQ11
            end
        end
    end

    // Holds the software-written configuration.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEBUG_PINS; i++) begin
                dbg_cfg[i] <= RST_DEBUG_CFG; // see RQ2, see RQ3, see RQ4
            end
            pin_drive_strength         <= 1'b0; // see RQ5
            sync_high                  <= RST_SYNC_HIGH; // see RQ6
            sync_low                   <= RST_SYNC_LOW; // see RQ7
            preamble_quality_threshold <= '0;
        end else begin
            dbg_cfg                    <= next_dbg_cfg;
            pin_drive_strength         <= next_pin_drive_strength;
            sync_high                  <= next_sync_high;
            sync_low                   <= next_sync_low;
            preamble_quality_threshold <= next_preamble_quality_threshold;
        end
    end

    // ==========================================================================
    // Register reads
    // ==========================================================================
    // Read data appear one cycle after the strobe and are zero otherwise.
    always_comb begin
        next_reg_rdata = RST_ZERO_BYTE;
        if (reg_read) begin
            if (reg_addr == ADDR_SYNC_HIGH) begin
                next_reg_rdata = sync_high; // see RQ6
            end else if (reg_addr == ADDR_SYNC_LOW) begin
                next_reg_rdata = sync_low; // see RQ7
            end else if (reg_addr == ADDR_PKT_CTRL) begin
                next_reg_rdata = {preamble_quality_threshold, PQT_LOW_PAD};
            end else if (reg_addr == ADDR_DEBUG_TWO) begin
                next_reg_rdata = cfg_byte(dbg_cfg[2], 1'b0); // see RQ11
            end else if (reg_addr == ADDR_DEBUG_ONE) begin
                next_reg_rdata = cfg_byte(dbg_cfg[1], pin_drive_strength); // see RQ5
            end else if (reg_addr == ADDR_DEBUG_ZERO) begin
                next_reg_rdata = cfg_byte(dbg_cfg[0], 1'b0); // see RQ11
            end else if (reg_addr == ADDR_FREQ_ESTIMATE) begin
                next_reg_rdata = freq_offset_estimate; // see RQ8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= RST_ZERO_BYTE;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ==========================================================================
    // Debug pins
    // ==========================================================================
    // One driver per pin; index equals the pin number.
    for (genvar p = 0; p < DEBUG_PINS; p++) begin : g_pin
        debug_pin_driver u_driver (
            .clk           (clk),
            .sys_rst       (sys_rst),
            .cfg           (dbg_cfg[p]),
            .radio_signals (radio_signals),
            .pin           (pin_level[p])
        );
    end

    assign debug_pin_two  = pin_level[2]; // see RQ2
    assign debug_pin_one  = pin_level[1]; // see RQ3
    assign debug_pin_zero = pin_level[0]; // see RQ4

    // ==========================================================================
    // Preamble quality and sync word match
    // ==========================================================================
    preamble_quality_counter u_quality (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .restart    (rx_restart),
        .bit_valid  (rx_bit_valid),
        .bit_in     (rx_bit),
        .threshold  (preamble_quality_threshold),
        .quality_ok (preamble_ok)
    );

    // Shifts received bits in and flags a match only once the preamble is good.
    always_comb begin
        next_rx_history    = rx_history;
        next_sync_detected = 1'b0;
        if (rx_restart) begin
            next_rx_history = '0;
        end else if (rx_bit_valid) begin
            next_rx_history    = {rx_history[SYNC_W-2:0], rx_bit};
            next_sync_detected = preamble_ok && (next_rx_history == {sync_high, sync_low}); // see RQ10
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_history    <= '0;
            sync_detected <= 1'b0;
        end else begin
            rx_history    <= next_rx_history;
            sync_detected <= next_sync_detected;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_sync_high_reset: assert property (@(posedge clk) // see RQ6
        sys_rst |=> sync_high == RST_SYNC_HIGH && sync_low == RST_SYNC_LOW)
        else $error("Sync word bytes did not reset to their defaults.");

    a_sync_low_rw: assert property (@(posedge clk) disable iff (sys_rst) // see RQ7
        (reg_write && reg_addr == ADDR_SYNC_LOW) ##1 (reg_read && reg_addr == ADDR_SYNC_LOW)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Low sync byte did not read back what was written.");

    a_sync_high_rw: assert property (@(posedge clk) disable iff (sys_rst) // see RQ6
        (reg_read && reg_addr == ADDR_SYNC_HIGH) |=> reg_rdata == $past(sync_high))
        else $error("High sync byte read returned the wrong value.");

    a_select_reset: assert property (@(posedge clk) // see RQ2
        sys_rst |=> dbg_cfg[2].select == '0 && dbg_cfg[1].select == '0 && dbg_cfg[0].select == '0)
        else $error("Debug selectors did not reset to zero.");

    a_select_one_write: assert property (@(posedge clk) disable iff (sys_rst) // see RQ3
        (reg_write && reg_addr == ADDR_DEBUG_ONE) |=> dbg_cfg[1].select == $past(reg_wdata[SEL_MSB:0]))
        else $error("Pin one selector did not take the written value.");

    a_select_zero_pin: assert property (@(posedge clk) disable iff (sys_rst) // see RQ4
        (reg_write && reg_addr == ADDR_DEBUG_ZERO && !reg_wdata[INV_BIT]) ##1 radio_signals[dbg_cfg[0].select]
        |=> debug_pin_zero)
        else $error("Pin zero did not follow its newly selected signal.");

    a_drive_strength: assert property (@(posedge clk) disable iff (sys_rst) // see RQ5
        (reg_write && reg_addr == ADDR_DEBUG_ONE) |=> pin_drive_strength == $past(reg_wdata[DRIVE_BIT]))
        else $error("Drive strength did not follow bit 7 of the pin one register.");

    a_unused_bit_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RQ11
        (reg_read && (reg_addr == ADDR_DEBUG_TWO || reg_addr == ADDR_DEBUG_ZERO)) |=> !reg_rdata[DRIVE_BIT])
        else $error("Unused bit 7 read back as one.");

    a_freq_status: assert property (@(posedge clk) disable iff (sys_rst) // see RQ8
        (reg_read && reg_addr == ADDR_FREQ_ESTIMATE) |=> reg_rdata == $past(freq_offset_estimate))
        else $error("Frequency offset status read returned the wrong value.");

    a_sync_needs_quality: assert property (@(posedge clk) disable iff (sys_rst) // see RQ10
        sync_detected |-> $past(preamble_ok) && $past(rx_bit_valid))
        else $error("Sync detected without sufficient preamble quality.");

    c_sync_found: cover property (@(posedge clk) disable iff (sys_rst) sync_detected);
    c_inverted_pin: cover property (@(posedge clk) disable iff (sys_rst) dbg_cfg[2].invert && debug_pin_two);
    c_drive_max: cover property (@(posedge clk) disable iff (sys_rst) pin_drive_strength);
    c_quality_gate: cover property (@(posedge clk) disable iff (sys_rst)
        preamble_quality_threshold != '0 && preamble_ok);

endmodule

`default_nettype wire

/* src/radio_debug_pkg.sv */
`default_nettype none

package radio_debug_pkg;

    // ==========================================================================
    // Register bus shape
    // ==========================================================================
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ==========================================================================
    // Register offsets
    // ==========================================================================
    localparam logic [ADDR_W-1:0] ADDR_SYNC_HIGH     = 16'hDF00;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_LOW      = 16'hDF01;
    localparam logic [ADDR_W-1:0] ADDR_PKT_CTRL      = 16'hDF03;
    localparam logic [ADDR_W-1:0] ADDR_DEBUG_TWO     = 16'hDF2F;
    localparam logic [ADDR_W-1:0] ADDR_DEBUG_ONE     = 16'hDF30;
    localparam logic [ADDR_W-1:0] ADDR_DEBUG_ZERO    = 16'hDF31;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_ESTIMATE = 16'hDF38;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [DATA_W-1:0] RST_SYNC_HIGH = 8'hD3;
    localparam logic [DATA_W-1:0] RST_SYNC_LOW  = 8'h91;
    localparam logic [DATA_W-1:0] RST_ZERO_BYTE = 8'h00;

    // ==========================================================================
    // Field layout
    // ==========================================================================
    localparam int SEL_W       = 6;
    localparam int SEL_MSB     = 5;
    localparam int INV_BIT     = 6;
    localparam int DRIVE_BIT   = 7;
    localparam int PQT_W       = 3;
    localparam int PQT_MSB     = 7;
    localparam int PQT_LSB     = 5;
    localparam int SYNC_W      = 16;
    localparam int DEBUG_PINS  = 3;
    localparam int NUM_SIGNALS = 64;
    localparam logic [PQT_LSB-1:0] PQT_LOW_PAD = 5'h00;

    // ==========================================================================
    // Preamble quality counter
    // ==========================================================================
    localparam int                   PQ_COUNT_W   = 5;
    localparam logic [PQ_COUNT_W-1:0] PQ_DEC      = 5'h08;
    localparam logic [PQ_COUNT_W-1:0] PQ_INC      = 5'h01;
    localparam logic [PQ_COUNT_W-1:0] PQ_MAX      = 5'h1F;
    localparam logic [PQ_COUNT_W-1:0] PQ_ZERO     = 5'h00;
    localparam logic [1:0]           PQ_SCALE_PAD = 2'h0;

    // Selector and polarity of one debug output pin.
    typedef struct packed {
        logic             invert;
        logic [SEL_W-1:0] select;
    } debug_cfg_s;

    localparam debug_cfg_s RST_DEBUG_CFG = '{invert: 1'b0, select: 6'h00};

endpackage

`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top import radio_debug_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus, model and bookkeeping
    // ==========================================================
    logic clk, sys_rst, reg_write, reg_read, rx_restart, rx_bit_valid, rx_bit;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, freq_offset_estimate, d;
    logic [NUM_SIGNALS-1:0] radio_signals;
    logic pin2, pin1, pin0, drive, pq_ok, sync_det;
    logic [ADDR_W-1:0] addrs[6] = '{ADDR_SYNC_HIGH, ADDR_SYNC_LOW, ADDR_PKT_CTRL,
                                     ADDR_DEBUG_TWO, ADDR_DEBUG_ONE, ADDR_DEBUG_ZERO};
    int masks[6] = '{8'hFF, 8'hFF, 8'hE0, 8'h7F, 8'hFF, 8'h7F};
    int model[6] = '{8'hD3, 8'h91, 8'h00, 8'h00, 8'h00, 8'h00};
    int bad_count = 0, checks_done = 0, cycles = 0;
    radio_debug_out_sync_regs i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .radio_signals(radio_signals),
        .freq_offset_estimate(freq_offset_estimate), .rx_restart(rx_restart), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .debug_pin_two(pin2), .debug_pin_one(pin1), .debug_pin_zero(pin0),
        .pin_drive_strength(drive), .preamble_ok(pq_ok), .sync_detected(sync_det));
    // Free running clock, 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(logic got, logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    // One-cycle write strobe; the model follows with the field mask applied.
    task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] v);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        for (int i = 0; i < 6; i++) if (addrs[i] === a) model[i] = v & masks[i];
    endtask
    // One-cycle read strobe; data taken in the following cycle only.
    task automatic rd(logic [ADDR_W-1:0] a);
        @(posedge clk);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Restart the receiver, then send a word MSB first one bit per cycle.
    task automatic send_word(logic [15:0] w);
        @(posedge clk);
        rx_restart <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            rx_restart <= 1'b0; rx_bit_valid <= 1'b1; rx_bit <= w[i];
        end
        @(posedge clk);
        rx_bit_valid <= 1'b0;
        #1;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        sys_rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_write = 1'b0; reg_read = 1'b0;
        radio_signals = '0; freq_offset_estimate = 8'h00; rx_restart = 1'b0; rx_bit_valid = 1'b0; rx_bit = 1'b0;
        void'($urandom(32'h2ce8));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        freq_offset_estimate <= 8'($urandom);
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i]);
            chk_byte(d, 8'(model[i]));
        end
        rd(ADDR_FREQ_ESTIMATE);
        chk_byte(d, freq_offset_estimate);
        $display("test reset values done");
        for (int n = 0; n < 3; n++) for (int i = 0; i < 6; i++) begin
            wr(addrs[i], 8'($urandom));
            rd(addrs[i]);
            chk_byte(d, 8'(model[i]));
        end
        wr(16'hDF02, 8'hFF);
        rd(16'hDF02);
        chk_byte(d, 8'h00);
        wr(ADDR_FREQ_ESTIMATE, ~freq_offset_estimate);
        rd(ADDR_FREQ_ESTIMATE);
        chk_byte(d, freq_offset_estimate);
        $display("test register access done");
        for (int n = 0; n < 8; n++) begin
            radio_signals <= {32'($urandom), 32'($urandom)};
            for (int i = 3; i < 6; i++) wr(addrs[i], 8'($urandom));
            repeat (3) @(posedge clk);
            #1;
            chk_bit(pin2, radio_signals[model[3] & 63] ^ model[3][6]);
            chk_bit(pin1, radio_signals[model[4] & 63] ^ model[4][6]);
            chk_bit(pin0, radio_signals[model[5] & 63] ^ model[5][6]);
            chk_bit(drive, model[4][7]);
        end
        $display("test debug pins done");
        wr(ADDR_PKT_CTRL, 8'h00);
        send_word({8'(model[0]), 8'(model[1])});
        chk_bit(sync_det, 1'b1);
        @(posedge clk);
        #1 chk_bit(sync_det, 1'b0);
        wr(ADDR_PKT_CTRL, 8'hE0);
        send_word({8'(model[0]), 8'(model[1])});
        chk_bit(sync_det, 1'b0);
        chk_bit(pq_ok, 1'b0);
        $display("test sync detection done");
        // Software idles the block for four cycles; sync_det must then read low.
        repeat (4) @(posedge clk);
        #1 chk_bit(sync_det, 1'b0);
        $display("test idle done");
        end_sim();
    end
endmodule
`default_nettype wire
